// ===== sim/eep_link_checker.sv
// Timing checks on the two-wire link and the device state flags
`timescale 1ns/1ps
module eep_link_checker
	import eep_pkg::*;
(
	input  wire logic              lclk_i,
	input  wire logic              reset_i,
	input  wire logic              scl,
	input  wire logic              sda,
	input  wire logic              sda_d_oe,
	input  wire logic              busy_o,
	input  wire logic [ADDR_W-1:0] ptr_o
);
	logic [15:0] busy_cnt_reg;

	// Length of the running write cycle, in link clock cycles
	always_ff @(posedge lclk_i) begin
		if (reset_i || !busy_o)
			busy_cnt_reg <= 16'h0000;
		else
			busy_cnt_reg <= busy_cnt_reg + 16'h0001;
	end

	default clocking lclk_cb @(posedge lclk_i); endclocking
	default disable iff (reset_i);

	AST_BUSY_SILENT: assert property (busy_o |-> !sda_d_oe)
		else $error("device pulls the data line while busy");
	AST_BUSY_FROM_STOP: assert property ($rose(busy_o) |-> scl && sda)
		else $error("write cycle began away from an idle bus");
	AST_BUSY_HOLD: assert property ($rose(busy_o) |=> busy_o [*8])
		else $error("write cycle ended at once");
	AST_BUSY_LENGTH: assert property ($fell(busy_o) |->
		(int'(busy_cnt_reg) >= WR_CYCLES - 2 &&
		int'(busy_cnt_reg) <= WR_CYCLES + 2))
		else $error("write cycle length wrong");
	AST_BUSY_PTR: assert property (busy_o && $past(busy_o) |->
		$stable(ptr_o))
		else $error("pointer moved during write cycle");
	AST_PTR_SPACING: assert property ($changed(ptr_o) |=>
		$stable(ptr_o) [*8])
		else $error("pointer stepped twice within one bit");
	// Data may only move while the clock is low, or Start and Stop break
	AST_SDA_SCL_HIGH: assert property (scl && $past(scl) |->
		$stable(sda_d_oe))
		else $error("device moved data while clock high");
	AST_STOP_RELEASE: assert property (scl && $past(scl) && $rose(sda)
		|=> !sda_d_oe [*8])
		else $error("device drives the line after Stop");
endmodule : eep_link_checker

// ===== sim/i2c_eeprom_read_and_ack_poll_tb.sv
// Testbench: master and EEPROM ends joined over the two-wire link
`timescale 1ns/1ps
module i2c_eeprom_read_and_ack_poll_tb;
	import eep_pkg::*;
	logic             clk_i = 1'b0;
	logic             lclk_i = 1'b0;
	logic             reset_i = 1'b1;
	logic [SEL_W-1:0] dev_sel = 3'h5;
	logic [SEL_W-1:0] host_sel = 3'h5;
	logic             cmd_valid_i = 1'b0;
	eep_op_type       cmd_op_i = OP_POLL;
	logic [7:0]       cmd_addr_i = 8'h00;
	logic [7:0]       cmd_data_i = 8'h00;
	logic [7:0]       cmd_len_i = 8'h00;
	logic             rd_ready_i = 1'b0;
	logic             rd_hold = 1'b0;
	logic             cmd_ready_o, done_o, nack_o, rd_valid_o, busy_o;
	logic [7:0]       rd_data_o, ptr_o;
	logic [7:0]       mem [256];
	logic [7:0]       ptr_m = 8'h00;
	logic [7:0]       exp_q [$];
	int               n_mismatch = 0;
	int               cmp_count = 0;
	int               dur;

	always #4 clk_i = !clk_i;
	always #16 lclk_i = !lclk_i;

	eep_link_if eep_link_if_inst ();
	eep_dev eep_dev_inst (.lclk_i(lclk_i), .reset_i(reset_i),
		.link(eep_link_if_inst.device), .sel_i(dev_sel),
		.busy_o(busy_o), .ptr_o(ptr_o));
	eep_host eep_host_inst (.clk_i(clk_i), .reset_i(reset_i),
		.link(eep_link_if_inst.master), .sel_i(host_sel),
		.cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
		.cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i),
		.cmd_data_i(cmd_data_i), .cmd_len_i(cmd_len_i), .done_o(done_o),
		.nack_o(nack_o), .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i),
		.rd_data_o(rd_data_o));
	eep_link_checker eep_link_checker_inst (.lclk_i(lclk_i),
		.reset_i(reset_i), .scl(eep_link_if_inst.scl),
		.sda(eep_link_if_inst.sda), .sda_d_oe(eep_link_if_inst.sda_d_oe),
		.busy_o(busy_o), .ptr_o(ptr_o));

	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : results

	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Expected bytes of a read, and where the pointer ends up
	function automatic void model_read(input eep_op_type op,
		input logic [7:0] a, input logic [7:0] len);
		logic [7:0] s;
		s = (op == OP_CUR) ? ptr_m : a;
		for (int i = 0; i <= int'(len); i++)
			exp_q.push_back(mem[8'(s + i)]);
		ptr_m = 8'(s + len + 8'h01);
	endfunction : model_read

	task automatic do_cmd(input eep_op_type op, input logic [7:0] a,
		input logic [7:0] d, input logic [7:0] len);
		int t;
		for (t = 0; t < 30000 && cmd_ready_o !== 1'b1; t++) begin
			@(posedge clk_i);
			#1;
		end
		cmd_op_i = op;
		cmd_addr_i = a;
		cmd_data_i = d;
		cmd_len_i = len;
		cmd_valid_i = 1'b1;
		@(posedge clk_i);
		#1;
		cmd_valid_i = 1'b0;
		for (dur = 0; dur < 30000 && done_o !== 1'b1; dur++) begin
			@(posedge clk_i);
			#1;
		end
		// A hung handshake is a failure, not a silent skip
		if (t >= 30000 || dur >= 30000) begin
			n_mismatch++;
			results();
		end
	endtask : do_cmd

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		do_cmd(OP_WRITE, a, d, 8'h00);
		chk("write nack", 8'h00, {7'h00, nack_o});
		mem[a] = d;
		ptr_m = 8'(a + 8'h01);
	endtask : wr

	task automatic do_rd(input eep_op_type op, input logic [7:0] a,
		input logic [7:0] len);
		model_read(op, a, len);
		do_cmd(op, a, 8'h00, len);
		chk("read nack", 8'h00, {7'h00, nack_o});
		chk("pointer", ptr_m, ptr_o);
	endtask : do_rd

	// Popping side of the read FIFO, stalled at random
	always @(posedge clk_i) begin
		if (rd_valid_o === 1'b1 && rd_ready_i === 1'b1)
			chk("read byte", (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX,
				rd_data_o);
		#1;
		rd_ready_i <= !rd_hold && ($urandom % 4 != 0);
	end

	initial begin
		// Worst case with every random pick a write and poll stays below
		repeat (99000) @(posedge clk_i);
		n_mismatch++;
		results();
	end

	initial begin
		logic [7:0] a;
		void'($urandom(23372));
		for (int i = 0; i < 256; i++)
			mem[i] = MEM_RESET;
		repeat (20) @(posedge clk_i);
		#1;
		reset_i = 1'b0;
		repeat (8) @(posedge clk_i);
		#1;
		chk("pointer after reset", PTR_RESET, ptr_o);
		wr(8'h10, 8'hA5);
		do_cmd(OP_CUR, 8'h00, 8'h00, 8'h00);
		chk("read while busy", 8'h01, {7'h00, nack_o});
		do_cmd(OP_POLL, 8'h00, 8'h00, 8'h00);
		chk("poll nack", 8'h00, {7'h00, nack_o});
		chk("poll outlasts write", 8'h01, {7'h00, dur > 2000});
		chk("busy after poll", 8'h00, {7'h00, busy_o});
		do_cmd(OP_POLL, 8'h00, 8'h00, 8'h00);
		chk("idle poll short", 8'h01, {7'h00, dur < 1000});
		do_rd(OP_CUR, 8'h00, 8'h00);
		do_rd(OP_RAND, 8'h10, 8'h00);
		do_rd(OP_RAND, 8'hFE, 8'h03);
		// Wrong select bits: refused, pointer left alone
		host_sel = dev_sel ^ 3'h1;
		do_cmd(OP_CUR, 8'h00, 8'h00, 8'h00);
		chk("foreign select", 8'h01, {7'h00, nack_o});
		chk("pointer kept", ptr_m, ptr_o);
		host_sel = dev_sel;
		do_rd(OP_CUR, 8'h00, 8'h01);
		// Full FIFO must stall the bus clock until space frees
		rd_hold = 1'b1;
		fork
			do_rd(OP_RAND, 8'h0C, 8'h0B);
			begin
				repeat (9000) @(posedge clk_i);
				#1;
				chk("stalled clock", 8'h00,
					{7'h00, eep_link_if_inst.scl});
				chk("stalled ready", 8'h00, {7'h00, cmd_ready_o});
				chk("fifo full", 8'h01, {7'h00, rd_valid_o});
				rd_hold = 1'b0;
			end
		join
		for (int k = 0; k < 10; k++) begin
			a = 8'($urandom);
			case ($urandom % 3)
				0: begin
					wr(a, 8'($urandom));
					do_cmd(OP_POLL, 8'h00, 8'h00, 8'h00);
				end
				1: do_rd(OP_RAND, a, 8'($urandom % 4));
				default: do_rd(OP_CUR, a, 8'($urandom % 3));
			endcase
		end
		repeat (200) @(posedge clk_i);
		#1;
		chk("fifo drained", 8'h00, {7'h00, rd_valid_o});
		chk("bytes missing", 8'h00, 8'(exp_q.size()));
		results();
	end
endmodule : i2c_eeprom_read_and_ack_poll_tb

// ===== verilog/eep_dev.sv
`timescale 1ns/1ps
// EEPROM end of the two-wire link: polling, reads and address pointer
// How it works
// - No acknowledge to control bytes while writing
// - Write cycle starts at Stop; polling may follow
// - Master polls with Start plus write control
// - Master repeats Start and control until acknowledged
// - Idle device acknowledges; master then continues
// - Read control byte carries direction bit one
// - Current read returns byte after last accessed
// - One byte, master nacks, Stop, line released
// - Address via write transfer, repeated Start keeps it
// - Read control after restart returns addressed byte
// - Pointer advances past byte just read
// - Master acks for more, nack and Stop ends
// - Pointer increments after every completed data byte
// - Pointer wraps from top location to zero
// - Respond only to type 1010 and select
// - Acknowledged address byte loads the pointer
module eep_dev
	import eep_pkg::*;
(
	input  wire logic             lclk_i,
	input  wire logic             reset_i,
	eep_link_if.device            link,
	input  wire logic [SEL_W-1:0] sel_i,
	output logic                  busy_o,
	output logic [ADDR_W-1:0]     ptr_o
);

	typedef enum logic [3:0] {
		ST_IDLE, ST_CTRL, ST_CTRL_ACK, ST_ADDR, ST_ADDR_ACK,
		ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK
	} eep_dev_state_type;

	eep_dev_state_type state_reg;
	eep_dev_state_type state_next;
	logic              scl_s1_reg;
	logic              scl_s2_reg;
	logic              scl_s3_reg;
	logic              sda_s1_reg;
	logic              sda_s2_reg;
	logic              sda_s3_reg;
	logic [7:0]        sh_reg;
	logic [7:0]        sh_next;
	logic [3:0]        cnt_reg;
	logic [3:0]        cnt_next;
	logic              oe_reg;
	logic              oe_next;
	logic [ADDR_W-1:0] ptr_reg;
	logic [ADDR_W-1:0] ptr_next;
	logic              rw_reg;
	logic              rw_next;
	logic              mack_reg;
	logic              mack_next;
	logic              armed_reg;
	logic              armed_next;
	logic [BUSY_W-1:0] busy_cnt_reg;
	logic              busy_reg;
	logic [7:0]        mem_reg [MEM_DEPTH];

	wire               scl_rise;
	wire               scl_fall;
	wire               bus_start;
	wire               bus_stop;
	wire               byte_in;
	wire               ctrl_match;
	wire               rx_state;
	wire               mem_we;
	wire [7:0]         rd_byte;
	wire [ADDR_W-1:0]  ptr_inc;

	// Pins come from the master's domain, so two flops before any use
	assign scl_rise  = scl_s2_reg && !scl_s3_reg;
	assign scl_fall  = !scl_s2_reg && scl_s3_reg;
	assign bus_start = scl_s2_reg && scl_s3_reg && sda_s3_reg && !sda_s2_reg;
	assign bus_stop  = scl_s2_reg && scl_s3_reg && !sda_s3_reg && sda_s2_reg;
	assign byte_in   = (cnt_reg == BITS_BYTE);
	assign ctrl_match = (sh_reg[7:4] == DEV_TYPE)
		&& (sh_reg[3:1] == sel_i)
		&& !busy_reg;
	assign rx_state  = (state_reg == ST_CTRL) || (state_reg == ST_ADDR)
		|| (state_reg == ST_WDATA);
	assign mem_we    = (state_reg == ST_WDATA) && scl_fall && byte_in
		&& !bus_start && !bus_stop;
	assign rd_byte   = mem_reg[ptr_reg];
	// Plain binary add wraps the top location back to zero
	assign ptr_inc   = ptr_reg + 8'h01;

	always_comb begin
		state_next = state_reg;
		sh_next    = sh_reg;
		cnt_next   = cnt_reg;
		oe_next    = oe_reg;
		ptr_next   = ptr_reg;
		rw_next    = rw_reg;
		mack_next  = mack_reg;
		armed_next = armed_reg;
		if (bus_start) begin
			// Repeated Start disarms the write cycle (the byte stays stored) but keeps the pointer
			state_next = ST_CTRL;
			cnt_next   = 4'h0;
			oe_next    = 1'b0;
			armed_next = 1'b0;
		end else if (bus_stop) begin
			state_next = ST_IDLE;
			oe_next    = 1'b0;
			armed_next = 1'b0;
		end else if (rx_state && scl_rise) begin
			sh_next  = {sh_reg[6:0], sda_s2_reg};
			cnt_next = cnt_reg + 4'h1;
		end else if (scl_fall) begin
			case (state_reg)
				ST_CTRL: begin
					if (byte_in) begin
						cnt_next = 4'h0;
						if (ctrl_match) begin
							oe_next    = 1'b1;
							rw_next    = sh_reg[0];
							state_next = ST_CTRL_ACK;
						end else begin
							// Stay off the line until a new Start
							state_next = ST_IDLE;
						end
					end
				end
				ST_ADDR: begin
					if (byte_in) begin
						cnt_next   = 4'h0;
						ptr_next   = sh_reg;
						oe_next    = 1'b1;
						state_next = ST_ADDR_ACK;
					end
				end
				ST_WDATA: begin
					if (byte_in) begin
						cnt_next   = 4'h0;
						ptr_next   = ptr_inc;
						armed_next = 1'b1;
						oe_next    = 1'b1;
						state_next = ST_WDATA_ACK;
					end
				end
				ST_CTRL_ACK: begin
					if (rw_reg == RW_READ) begin
						// First bit goes out on the fall that ends the ack
						sh_next    = rd_byte;
						oe_next    = !rd_byte[7];
						cnt_next   = 4'h0;
						state_next = ST_RDATA;
					end else begin
						oe_next    = 1'b0;
						state_next = ST_ADDR;
					end
				end
				ST_ADDR_ACK, ST_WDATA_ACK: begin
					oe_next    = 1'b0;
					state_next = ST_WDATA;
				end
				ST_RDATA: begin
					if (byte_in) begin
						oe_next    = 1'b0;
						ptr_next   = ptr_inc;
						state_next = ST_RACK;
					end else begin
						sh_next = {sh_reg[6:0], 1'b0};
						oe_next = !sh_reg[6];
					end
				end
				ST_RACK: begin
					if (mack_reg) begin
						sh_next    = rd_byte;
						oe_next    = !rd_byte[7];
						cnt_next   = 4'h0;
						state_next = ST_RDATA;
					end else begin
						state_next = ST_IDLE;
					end
				end
				default: begin
					state_next = state_reg;
				end
			endcase
		end else if (scl_rise) begin
			if (state_reg == ST_RDATA) begin
				cnt_next = cnt_reg + 4'h1;
			end
			if (state_reg == ST_RACK) begin
				mack_next = !sda_s2_reg;
			end
		end
	end

	always_ff @(posedge lclk_i) begin
		scl_s1_reg <= link.scl;
		scl_s2_reg <= scl_s1_reg;
		scl_s3_reg <= scl_s2_reg;
		sda_s1_reg <= link.sda;
		sda_s2_reg <= sda_s1_reg;
		sda_s3_reg <= sda_s2_reg;
	end

	always_ff @(posedge lclk_i) begin
		if (reset_i) begin
			state_reg <= ST_IDLE;
			sh_reg    <= 8'h00;
			cnt_reg   <= 4'h0;
			oe_reg    <= 1'b0;
			ptr_reg   <= PTR_RESET;
			rw_reg    <= RW_WRITE;
			mack_reg  <= 1'b0;
			armed_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			sh_reg    <= sh_next;
			cnt_reg   <= cnt_next;
			oe_reg    <= oe_next;
			ptr_reg   <= ptr_next;
			rw_reg    <= rw_next;
			mack_reg  <= mack_next;
			armed_reg <= armed_next;
		end
	end

	// Timed write cycle; polling is refused until it runs out
	always_ff @(posedge lclk_i) begin
		if (reset_i) begin
			busy_cnt_reg <= '0;
			busy_reg     <= 1'b0;
		end else if (bus_stop && armed_reg) begin
			busy_cnt_reg <= BUSY_LOAD;
			busy_reg     <= 1'b1;
		end else if (busy_cnt_reg != '0) begin
			busy_cnt_reg <= busy_cnt_reg - 1'b1;
			busy_reg     <= (busy_cnt_reg != BUSY_W'(1));
		end
	end

	always_ff @(posedge lclk_i) begin
		if (reset_i) begin
			for (int i = 0; i < MEM_DEPTH; i++) begin
				mem_reg[i] <= MEM_RESET;
			end
		end else if (mem_we) begin
			mem_reg[ptr_reg] <= sh_reg;
		end
	end

	// Open drain: only ever pulls low
	assign link.sda_d_o  = 1'b0;
	assign link.sda_d_oe = oe_reg;
	assign busy_o        = busy_reg;
	assign ptr_o         = ptr_reg;

endmodule : eep_dev

// ===== verilog/eep_host.sv
`timescale 1ns/1ps
// Bus master end: command sequencer, bit engine and read data FIFO

module eep_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_i,
	input  wire logic             reset_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0]      wr_reg;
	logic [AW:0]      rd_reg;
	wire              push;
	wire              pop;

	assign in_ready_o  = !((wr_reg[AW] != rd_reg[AW])
		&& (wr_reg[AW-1:0] == rd_reg[AW-1:0]));
	assign out_valid_o = (wr_reg != rd_reg);
	assign out_data_o  = mem_reg[rd_reg[AW-1:0]];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wr_reg <= '0;
			rd_reg <= '0;
		end else begin
			if (push) begin
				wr_reg <= wr_reg + 1'b1;
			end
			if (pop) begin
				rd_reg <= rd_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_reg[wr_reg[AW-1:0]] <= in_data_i;
		end
	end
endmodule : eep_fifo

module eep_host
	import eep_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             reset_i,
	eep_link_if.master            link,
	input  wire logic [SEL_W-1:0] sel_i,
	input  wire logic             cmd_valid_i,
	output logic                  cmd_ready_o,
	input  wire eep_op_type       cmd_op_i,
	input  wire logic [7:0]       cmd_addr_i,
	input  wire logic [7:0]       cmd_data_i,
	input  wire logic [7:0]       cmd_len_i,
	output logic                  done_o,
	output logic                  nack_o,
	output logic                  rd_valid_o,
	input  wire logic             rd_ready_i,
	output logic [7:0]            rd_data_o
);
	typedef enum logic [1:0] {K_START, K_STOP, K_BYTE} eep_kind_type;
	typedef enum logic [3:0] {
		H_IDLE, H_START, H_CTRL, H_ADDR, H_WDATA,
		H_RSTART, H_CTRLR, H_RWAIT, H_READ, H_STOP
	} eep_host_state_type;

	eep_host_state_type state_reg;
	eep_host_state_type state_next;
	eep_kind_type       kind_reg;
	eep_kind_type       l_kind;
	eep_op_type         op_reg;
	logic [7:0]         addr_reg;
	logic [7:0]         wdata_reg;
	logic [7:0]         left_reg;
	logic [7:0]         left_next;
	logic               nack_reg;
	logic               nack_next;
	logic               done_reg;
	logic               ready_reg;
	logic               launch;
	logic [8:0]         l_tx;
	logic               push;
	logic               eng_busy_reg;
	logic [1:0]         ph_reg;
	logic [3:0]         nbit_reg;
	logic [4:0]         qcnt_reg;
	logic [8:0]         tx_reg;
	logic [8:0]         rx_reg;
	logic               scl_reg;
	logic               oe_reg;
	logic               sda_s1_reg;
	logic               sda_s2_reg;
	logic               fifo_ready;

	wire                eng_idle;
	wire                got_ack;
	wire                take;
	wire [7:0]          ctrl_w;
	wire [7:0]          ctrl_r;

	assign eng_idle = !eng_busy_reg;
	assign got_ack  = !rx_reg[0];
	assign take     = (state_reg == H_IDLE) && cmd_valid_i;
	assign ctrl_w   = {DEV_TYPE, sel_i, RW_WRITE};
	assign ctrl_r   = {DEV_TYPE, sel_i, RW_READ};

	always_comb begin
		state_next = state_reg;
		left_next  = left_reg;
		nack_next  = nack_reg;
		launch     = 1'b0;
		l_kind     = K_BYTE;
		l_tx       = 9'h1FF;
		push       = 1'b0;
		case (state_reg)
			H_IDLE: begin
				if (cmd_valid_i) begin
					launch     = 1'b1;
					l_kind     = K_START;
					left_next  = cmd_len_i;
					nack_next  = 1'b0;
					state_next = H_START;
				end
			end
			H_START: begin
				if (eng_idle) begin
					launch     = 1'b1;
					l_tx       = {(op_reg == OP_CUR) ? ctrl_r : ctrl_w, 1'b1};
					state_next = H_CTRL;
				end
			end
			H_CTRL: begin
				if (eng_idle) begin
					launch = 1'b1;
					if (!got_ack && op_reg == OP_POLL) begin
						l_kind     = K_START;
						state_next = H_START;
					end else if (!got_ack || op_reg == OP_POLL) begin
						nack_next  = !got_ack;
						l_kind     = K_STOP;
						state_next = H_STOP;
					end else if (op_reg == OP_CUR) begin
						launch     = 1'b0;
						state_next = H_RWAIT;
					end else begin
						l_tx       = {addr_reg, 1'b1};
						state_next = H_ADDR;
					end
				end
			end
			H_ADDR: begin
				if (eng_idle) begin
					launch = 1'b1;
					if (!got_ack) begin
						nack_next  = 1'b1;
						l_kind     = K_STOP;
						state_next = H_STOP;
					end else if (op_reg == OP_RAND) begin
						l_kind     = K_START;
						state_next = H_RSTART;
					end else begin
						l_tx       = {wdata_reg, 1'b1};
						state_next = H_WDATA;
					end
				end
			end
			H_WDATA: begin
				if (eng_idle) begin
					launch     = 1'b1;
					nack_next  = !got_ack;
					l_kind     = K_STOP;
					state_next = H_STOP;
				end
			end
			H_RSTART: begin
				if (eng_idle) begin
					launch     = 1'b1;
					l_tx       = {ctrl_r, 1'b1};
					state_next = H_CTRLR;
				end
			end
			H_CTRLR: begin
				if (eng_idle) begin
					if (got_ack) begin
						state_next = H_RWAIT;
					end else begin
						launch     = 1'b1;
						nack_next  = 1'b1;
						l_kind     = K_STOP;
						state_next = H_STOP;
					end
				end
			end
			H_RWAIT: begin
				// A full FIFO holds the clock still until the user drains it
				if (fifo_ready) begin
					launch     = 1'b1;
					l_tx       = {8'hFF, left_reg == 8'h00};
					state_next = H_READ;
				end
			end
			H_READ: begin
				if (eng_idle) begin
					push = 1'b1;
					if (left_reg == 8'h00) begin
						launch     = 1'b1;
						l_kind     = K_STOP;
						state_next = H_STOP;
					end else begin
						left_next  = left_reg - 8'h01;
						state_next = H_RWAIT;
					end
				end
			end
			H_STOP: begin
				if (eng_idle) begin
					state_next = H_IDLE;
				end
			end
			default: begin
				state_next = H_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_reg <= H_IDLE;
			op_reg    <= OP_POLL;
			addr_reg  <= 8'h00;
			wdata_reg <= 8'h00;
			left_reg  <= 8'h00;
			nack_reg  <= 1'b0;
			done_reg  <= 1'b0;
			ready_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			left_reg  <= left_next;
			nack_reg  <= nack_next;
			done_reg  <= (state_reg == H_STOP) && eng_idle;
			ready_reg <= (state_next == H_IDLE);
			if (take) begin
				op_reg    <= cmd_op_i;
				addr_reg  <= cmd_addr_i;
				wdata_reg <= cmd_data_i;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		sda_s1_reg <= link.sda;
		sda_s2_reg <= sda_s1_reg;
	end

	// Bit engine: quarter 0 sets data, 1 raises the clock, 2 samples,
	// 3 lowers the clock except for Stop; Start and Stop move the data line in quarter 2
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			eng_busy_reg <= 1'b0;
			kind_reg     <= K_STOP;
			ph_reg       <= 2'h0;
			nbit_reg     <= 4'h0;
			qcnt_reg     <= 5'h00;
			tx_reg       <= 9'h1FF;
			rx_reg       <= 9'h1FF;
			scl_reg      <= 1'b1;
			oe_reg       <= 1'b0;
		end else if (launch) begin
			eng_busy_reg <= 1'b1;
			kind_reg     <= l_kind;
			tx_reg       <= l_tx;
			ph_reg       <= 2'h0;
			nbit_reg     <= BITS_FRAME;
			qcnt_reg     <= QTR_LOAD;
		end else if (eng_busy_reg && qcnt_reg != 5'h00) begin
			qcnt_reg <= qcnt_reg - 5'h01;
		end else if (eng_busy_reg) begin
			qcnt_reg <= QTR_LOAD;
			ph_reg   <= ph_reg + 2'h1;
			case (ph_reg)
				2'h0: oe_reg <= (kind_reg == K_STOP)
					|| (kind_reg == K_BYTE && !tx_reg[8]);
				2'h1: scl_reg <= 1'b1;
				2'h2: begin
					if (kind_reg == K_BYTE) begin
						rx_reg <= {rx_reg[7:0], sda_s2_reg};
					end else begin
						oe_reg <= (kind_reg == K_START);
					end
				end
				default: begin
					scl_reg      <= (kind_reg == K_STOP);
					tx_reg       <= {tx_reg[7:0], 1'b1};
					nbit_reg     <= nbit_reg - 4'h1;
					eng_busy_reg <= (kind_reg == K_BYTE) && (nbit_reg != 4'h1);
				end
			endcase
		end
	end

	eep_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.reset_i     (reset_i),
		.in_valid_i  (push),
		.in_ready_o  (fifo_ready),
		.in_data_i   (rx_reg[8:1]),
		.out_valid_o (rd_valid_o),
		.out_ready_i (rd_ready_i),
		.out_data_o  (rd_data_o)
	);

	assign link.scl      = scl_reg;
	assign link.sda_m_o  = 1'b0;
	assign link.sda_m_oe = oe_reg;
	assign cmd_ready_o   = ready_reg;
	assign done_o        = done_reg;
	assign nack_o        = nack_reg;

endmodule : eep_host

// ===== verilog/eep_link_if.sv
`timescale 1ns/1ps
// Two-wire link between the bus master and the EEPROM
interface eep_link_if;
	logic scl;
	logic sda_m_o;
	logic sda_m_oe;
	logic sda_d_o;
	logic sda_d_oe;
	logic sda;

	// Open drain with pull-up: any enabled low driver pulls the line
	assign sda = !((sda_m_oe && !sda_m_o) || (sda_d_oe && !sda_d_o));

	modport master (output scl, output sda_m_o, output sda_m_oe, input sda);
	modport device (input scl, input sda, output sda_d_o, output sda_d_oe);
endinterface : eep_link_if

// ===== verilog/eep_pkg.sv
// Shared constants and types for the serial EEPROM link and its master
package eep_pkg;
	localparam logic [3:0]  DEV_TYPE    = 4'hA;
	localparam int          SEL_W       = 3;
	localparam int          ADDR_W      = 8;
	localparam int          MEM_DEPTH   = 256;
	localparam logic [7:0]  PTR_RESET   = 8'h00;
	localparam logic [7:0]  MEM_RESET   = 8'h00;
	localparam logic        RW_WRITE    = 1'b0;
	localparam logic        RW_READ     = 1'b1;
	localparam logic [3:0]  BITS_FRAME  = 4'h9;
	localparam logic [3:0]  BITS_BYTE   = 4'h8;
	// Device side runs on the 32 ns link clock
	localparam int          LCLK_NS     = 32;
	localparam int          WR_CYCLE_NS = 32000;
	// Least time, so rounded up
	localparam int          WR_CYCLES   = (WR_CYCLE_NS + LCLK_NS - 1) / LCLK_NS;
	localparam int          BUSY_W      = $clog2(WR_CYCLES + 1);
	localparam logic [BUSY_W-1:0] BUSY_LOAD = BUSY_W'(WR_CYCLES);
	// Master side: one bit is four quarter periods of the divided clock
	localparam int          CLK_NS      = 8;
	localparam int          QTR_NS      = 128;
	localparam int          QTR_CYCLES  = QTR_NS / CLK_NS;
	localparam logic [4:0]  QTR_LOAD    = 5'(QTR_CYCLES - 1);
	localparam int          FIFO_DEPTH  = 8;
	localparam int          FIFO_WIDTH  = 8;
	typedef enum logic [1:0] {OP_POLL, OP_CUR, OP_RAND, OP_WRITE} eep_op_type;
endpackage : eep_pkg
